/* src/cpu_timers.sv */
// three cpu timers with shared interrupt control/status and pci inta# latch
//
// Overview of operation
// - timers step on the cpu bus clock when no division is chosen.
// - a divider can slow the count rate down to one eighth.
// - the rate comes from the clock select field in bits 29:24.
// - counters only ever count upward from their start value.
// - live counts can be read while the timer keeps running.
// - writing a start value makes the counter count up from it.
// - reaching all ones raises the timer interrupt if control bits allow.
// - each timer has its own interrupt enable.
// - a timer can be stopped, or reloaded and restarted automatically.
// - at terminal count the counter restarts only if reload is enabled.
// - the control and status register sits at offset e4.
// - bits 10:8 are per-timer pending flags set on count completion.
// - the pci inta# input is latched and routed through this register.
// - control and status contents hold after an interrupt until cleared.
// - start values and live counts sit at distinct offsets.
// - a written start value stays until it is rewritten.
// - reading the control and status register clears pending timer flags.
// - start value registers are writable and readable.
// - live count registers are read only and show the running count.
// - reset clears the control and status register to zero.
// - a run bit of one starts its timer, zero stops it.
// - a new timer event wins over a read clear in the same cycle.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "cpu_timers_cfg.svh"
module cpu_timers
   import cpu_timers_pkg::*;
#(
   parameter int TIMER_W = 32
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic        pci_inta_n,
   output logic      [31:0] rd_data,
   output logic             nmi_irq,
   output logic             cpu_irq
);
   localparam logic [TIMER_W-1:0] CNT_MAX = '1;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // address compare, shared by the write and read decoders
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // clock select to divider limit: 0 runs at full rate, 7 and above at 1/8
   function automatic logic [2:0] div_limit(input clk_sel_t sel);
      logic [2:0] lim;
      lim = (sel >= 6'h07) ? `DIV_MAX_LIM : sel[2:0];
      return lim;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   word_t              ctrl_reg;       // writable control bits of the csr
   tmr_vec_t           pend_reg;       // timer pending flags
   tmr_vec_t           pend_next;
   logic               pci_pend_reg;
   logic               pci_pend_next;
   logic               sync1_reg;
   logic               sync2_reg;
   logic               sync3_reg;
   logic [2:0]         div_cnt_reg;
   logic               tick_reg;
   logic [TIMER_W-1:0] start_reg [3];
   logic [TIMER_W-1:0] live_cnt  [3];
   tmr_vec_t           tmr_evt;
   tmr_vec_t           load_vec;
   tmr_vec_t           run_vec;
   tmr_vec_t           ien_vec;
   tmr_vec_t           reload_vec;
   word_t              rd_data_reg;
   word_t              rd_data_next;
   word_t              csr_view;
   logic               nmi_irq_reg;
   logic               cpu_irq_reg;
   logic               csr_wr;
   logic               csr_rd;
   logic               pci_en;
   logic               pci_seen;
   logic               pci_clr;

   assign rd_data = rd_data_reg;
   assign nmi_irq = nmi_irq_reg;
   assign cpu_irq = cpu_irq_reg;

   // ----------------------------------------------------------------
   // decode and field extraction
   // ----------------------------------------------------------------

   // writes and reads of the csr and the start registers
   assign csr_wr     = wr_en && hit(addr, `OFF_CSR);
   assign csr_rd     = rd_en && hit(addr, `OFF_CSR);
   assign load_vec   = {wr_en && hit(addr, `OFF_SET_T2),
                        wr_en && hit(addr, `OFF_SET_T1),
                        wr_en && hit(addr, `OFF_SET_NMI)};
   assign run_vec    = ctrl_reg[`BIT_RUN_LSB +: 3];
   assign ien_vec    = ctrl_reg[`BIT_IEN_LSB +: 3];
   assign reload_vec = ctrl_reg[`BIT_RELOAD_LSB +: 3];
   assign pci_en     = ctrl_reg[`BIT_PCI_EN];
   assign pci_clr    = csr_wr && wr_data[`BIT_PCI_CLR];
   assign pci_seen   = !sync2_reg && !sync3_reg;

   // ----------------------------------------------------------------
   // control bits
   // ----------------------------------------------------------------

   // only the documented read/write bits store; clear and status bits do not
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg <= `CSR_RESET;
      end else if (csr_wr) begin
         ctrl_reg <= wr_data & `CSR_WMASK;
      end
   end

   // start values stay put until software writes them again
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            start_reg[i] <= `START_RESET;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (load_vec[i]) begin
               start_reg[i] <= wr_data[TIMER_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // timer clock divider
   // ----------------------------------------------------------------

   // one shared tick keeps the three timers in step; a select change takes
   // effect at once, as the running divider count is compared with the new limit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_cnt_reg <= 3'h0;
         tick_reg    <= 1'b0;
      end else if (div_cnt_reg >= div_limit(ctrl_reg[`CLKSEL_MSB:`CLKSEL_LSB])) begin
         div_cnt_reg <= 3'h0;
         tick_reg    <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 3'h1;
         tick_reg    <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_tmr
      logic [TIMER_W-1:0] start_sel;

      // a write loads the bus word at once; reload and restart use the stored value,
      // because the bus word is long gone by the time the count wraps
      assign start_sel = load_vec[g] ? wr_data[TIMER_W-1:0] : start_reg[g];

      timer_channel #(
         .W (TIMER_W)
      ) u_chan (
         .clk_sys   (clk_sys),
         .rst       (rst),
         .tick      (tick_reg),
         .run       (run_vec[g]),
         .reload_en (reload_vec[g]),
         .load      (load_vec[g]),
         .start_val (start_sel),
         .count     (live_cnt[g]),
         .terminal  (tmr_evt[g])
      );
   end

   // ----------------------------------------------------------------
   // pending flags and pci input
   // ----------------------------------------------------------------

   // three flops on the asynchronous pin; only stage two feeds stage three
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
      end else begin
         sync1_reg <= pci_inta_n;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // set beats clear; a csr read drops only flags without a new event
   always_comb begin
      pend_next     = tmr_evt | (pend_reg & ~{3{csr_rd}});
      pci_pend_next = pci_seen | (pci_pend_reg & ~pci_clr);
   end

   // flags hold until read or cleared, so software sees a stable picture
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_reg     <= 3'h0;
         pci_pend_reg <= 1'b0;
      end else begin
         pend_reg     <= pend_next;
         pci_pend_reg <= pci_pend_next;
      end
   end

   // interrupt lines toward the cpu, gated by the enables
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nmi_irq_reg <= 1'b0;
         cpu_irq_reg <= 1'b0;
      end else begin
         nmi_irq_reg <= pend_reg[0] && ien_vec[0];
         cpu_irq_reg <= (|(pend_reg[2:1] & ien_vec[2:1])) || (pci_pend_reg && pci_en);
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   // csr image: stored controls, live status, write-only and reserved as zero
   always_comb begin
      csr_view = ctrl_reg;
      csr_view[`BIT_PCI_PEND] = pci_pend_reg;
      csr_view[`BIT_PEND_LSB +: 3] = pend_reg;
   end

   // read mux; unmapped offsets answer zero
   always_comb begin
      rd_data_next = 32'h0000_0000;
      if (hit(addr, `OFF_CSR)) begin
         rd_data_next = csr_view;
      end else if (hit(addr, `OFF_SET_NMI)) begin
         rd_data_next = 32'(start_reg[0]);
      end else if (hit(addr, `OFF_SET_T1)) begin
         rd_data_next = 32'(start_reg[1]);
      end else if (hit(addr, `OFF_SET_T2)) begin
         rd_data_next = 32'(start_reg[2]);
      end else if (hit(addr, `OFF_LIVE_NMI)) begin
         rd_data_next = 32'(live_cnt[0]);
      end else if (hit(addr, `OFF_LIVE_T1)) begin
         rd_data_next = 32'(live_cnt[1]);
      end else if (hit(addr, `OFF_LIVE_T2)) begin
         rd_data_next = 32'(live_cnt[2]);
      end
   end

   // read data in the cycle after the strobe; a read never touches a counter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data_reg <= 32'h0000_0000;
      end else if (rd_en) begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking

   chk_reset_clears_csr: assert property (
      rst |=> (ctrl_reg == 32'h0000_0000) && (pend_reg == 3'h0) && !pci_pend_reg)
      else $error("csr not zero after reset");

   chk_event_sets_pending: assert property (
      disable iff (rst) tmr_evt[0] |=> pend_reg[0] ##1 nmi_irq == $past(ien_vec[0]))
      else $error("timer event lost or irq wrong");

   chk_read_clears_pend: assert property (
      disable iff (rst) csr_rd && pend_reg[1] && !tmr_evt[1] |=> !pend_reg[1])
      else $error("csr read did not clear pending");

   chk_pend_holds: assert property (
      disable iff (rst) pend_reg[1] && !csr_rd |=> pend_reg[1])
      else $error("pending flag dropped without read");

   chk_irq_masked: assert property (
      disable iff (rst) !ien_vec[0] && !csr_wr |=> !nmi_irq)
      else $error("nmi raised while disabled");

   chk_live_readback: assert property (
      disable iff (rst) rd_en && hit(addr, `OFF_LIVE_T1) |=> rd_data == 32'($past(live_cnt[1])))
      else $error("live count read wrong");

   chk_set_readback: assert property (
      disable iff (rst) wr_en && hit(addr, `OFF_SET_NMI) ##1 !wr_en ##1 rd_en && hit(addr, `OFF_SET_NMI)
      |=> rd_data == $past(wr_data, 3))
      else $error("start value readback wrong");

   chk_count_steps_up: assert property (
      disable iff (rst) tick_reg && run_vec[0] && !load_vec[0] && live_cnt[0] != CNT_MAX
      |=> live_cnt[0] == $past(live_cnt[0]) + 1'b1)
      else $error("timer did not step up by one");

   chk_stopped_holds: assert property (
      disable iff (rst) !run_vec[1] && !load_vec[1] |=> live_cnt[1] == $past(live_cnt[1]))
      else $error("stopped timer moved");

   chk_pci_latched: assert property (
      disable iff (rst) pci_seen && !pci_en |=> pci_pend_reg ##1
      (!cpu_irq || $past(pci_en) || $past(|(pend_reg[2:1] & ien_vec[2:1]))))
      else $error("inta not latched or leaked");

   chk_set_beats_clear: assert property (
      disable iff (rst) csr_rd && tmr_evt[0] |=> pend_reg[0])
      else $error("read clear beat a new timer event");

   chk_irq_from_pend: assert property (
      disable iff (rst) pend_reg[0] && ien_vec[0] |=> nmi_irq)
      else $error("pending nmi timer event not raised");

   chk_halt_at_max: assert property (
      disable iff (rst) tick_reg && run_vec[0] && $past(run_vec[0]) && !reload_vec[0] && !load_vec[0]
      && live_cnt[0] == CNT_MAX |=> live_cnt[0] == CNT_MAX)
      else $error("timer without reload left all ones");

   chk_reload_restarts: assert property (
      disable iff (rst) tick_reg && run_vec[1] && reload_vec[1] && !load_vec[1] && live_cnt[1] == CNT_MAX
      && $past(live_cnt[1]) != CNT_MAX |=> live_cnt[1] == $past(start_reg[1]))
      else $error("reload did not restart from the start value");

   chk_pci_clear: assert property (
      disable iff (rst) pci_clr && !pci_seen |=> !pci_pend_reg)
      else $error("pci pending not cleared");

   cov_timer_event: cover property (disable iff (rst) tmr_evt[0] && ien_vec[0] ##2 nmi_irq);
   cov_read_clear:  cover property (disable iff (rst) csr_rd && pend_reg[1]);
   cov_set_vs_clr:  cover property (disable iff (rst) csr_rd && tmr_evt[2]);
   cov_pci_irq:     cover property (disable iff (rst) pci_pend_reg && pci_en ##1 cpu_irq);
endmodule

/* src/cpu_timers_cfg.svh */
// register offsets, field positions and reset values of the cpu timer block
`ifndef CPU_TIMERS_CFG_SVH
`define CPU_TIMERS_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_CSR        8'he4
`define OFF_SET_NMI    8'he8
`define OFF_SET_T1     8'hec
`define OFF_SET_T2     8'hf0
`define OFF_LIVE_NMI   8'hf4
`define OFF_LIVE_T1    8'hf8
`define OFF_LIVE_T2    8'hfc

// ----------------------------------------------------------------
// control and status field positions
// ----------------------------------------------------------------
`define BIT_RUN_LSB    0
`define BIT_PCI_EN     3
`define BIT_PCI_CLR    4
`define BIT_PCI_PEND   5
`define BIT_PEND_LSB   8
`define BIT_IEN_LSB    12
`define BIT_RELOAD_LSB 15
`define CLKSEL_MSB     29
`define CLKSEL_LSB     24

// ----------------------------------------------------------------
// reset values, write mask and divider limit
// ----------------------------------------------------------------
`define CSR_RESET      32'h0000_0000
`define CSR_WMASK      32'h3f03_f00f
`define START_RESET    32'h0000_0000
`define DIV_MAX_LIM    3'h7

`endif

/* src/cpu_timers_pkg.sv */
// shared types of the cpu timer block
package cpu_timers_pkg;
   typedef logic [31:0] word_t;
   typedef logic [2:0]  tmr_vec_t;
   typedef logic [5:0]  clk_sel_t;
endpackage

/* src/timer_channel.sv */
// one up-counting timer with load, stop, reload and terminal event
`timescale 1ns/100ps
module timer_channel #(
   parameter int W = 32
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic         reload_en,
   input  wire logic         load,
   input  wire logic [W-1:0] start_val,
   output logic     [W-1:0] count,
   output logic             terminal
);
   localparam logic [W-1:0] CNT_MAX = '1;

   logic [W-1:0] count_reg;
   logic         halt_reg;
   logic         run_d_reg;
   logic         term_reg;

   assign count    = count_reg;
   assign terminal = term_reg;

   // remember run so a re-enable after a halt can restart the count
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_d_reg <= 1'b0;
      end else begin
         run_d_reg <= run;
      end
   end

   // counter: load wins, then restart after halt, then counting
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_reg <= '0;
         halt_reg  <= 1'b0;
      end else if (load) begin
         count_reg <= start_val;
         halt_reg  <= 1'b0;
      end else if (run && !run_d_reg && halt_reg) begin
         count_reg <= start_val;
         halt_reg  <= 1'b0;
      end else if (tick && run && !halt_reg) begin
         if (count_reg == CNT_MAX) begin
            if (reload_en) begin
               count_reg <= start_val;
            end else begin
               halt_reg <= 1'b1;
            end
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   // one-cycle event on the step that lands on all ones
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         term_reg <= 1'b0;
      end else begin
         term_reg <= tick && run && !halt_reg && !load && (count_reg == CNT_MAX - 1'b1);
      end
   end
endmodule

/* testbench/pci_irq_agent.sv */
// model of an external pci agent that pulls the shared inta# line low
`timescale 1ns/100ps
module pci_irq_agent (
   input  wire logic clk_sys,
   input  wire logic assert_req,
   output wire       pci_inta_n
);
   logic drive_low = 1'b0;

   // a real agent is synchronous to its own bus, so the pin moves just after an edge
   always @(posedge clk_sys) begin
      drive_low <= assert_req;
   end

   // open drain: a released line is pulled high by the board, never left at the old level
   assign pci_inta_n = drive_low ? 1'b0 : 1'bz;
   pullup (pci_inta_n);
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the cpu timer block and its pci inta# latch
`timescale 1ns/100ps
`include "cpu_timers_cfg.svh"
module tb_top;
   import cpu_timers_pkg::*;

   // ----------------------------------------------------------------
   // signals and control words
   // ----------------------------------------------------------------
   logic        clk_sys;
   logic        rst;
   logic [7:0]  addr;
   word_t       wr_data;
   logic        wr_en;
   logic        rd_en;
   logic        pci_req;
   wire         pci_inta_n;
   word_t       rd_data;
   logic        nmi_irq;
   logic        cpu_irq;
   int          n_mismatch;
   int          samples_checked;
   word_t       d;
   word_t       d0;
   localparam word_t RUN_NMI  = 32'h1 << `BIT_RUN_LSB;
   localparam word_t RUN_T1   = 32'h2 << `BIT_RUN_LSB;
   localparam word_t RUN_T2   = 32'h4 << `BIT_RUN_LSB;
   localparam word_t PCI_EN   = 32'h1 << `BIT_PCI_EN;
   localparam word_t PCI_CLR  = 32'h1 << `BIT_PCI_CLR;
   localparam word_t PCI_PEND = 32'h1 << `BIT_PCI_PEND;
   localparam word_t PEND_NMI = 32'h1 << `BIT_PEND_LSB;
   localparam word_t PEND_T1  = 32'h2 << `BIT_PEND_LSB;
   localparam word_t IEN_NMI  = 32'h1 << `BIT_IEN_LSB;
   localparam word_t IEN_T1   = 32'h2 << `BIT_IEN_LSB;
   localparam word_t RLD_T1   = 32'h2 << `BIT_RELOAD_LSB;
   logic [7:0]  offs [7] = '{`OFF_CSR, `OFF_SET_NMI, `OFF_SET_T1, `OFF_SET_T2,
                             `OFF_LIVE_NMI, `OFF_LIVE_T2, 8'h10};
   logic [5:0]  sels [4] = '{6'h00, 6'h01, 6'h07, 6'h3f};
   int          divs [4] = '{1, 2, 8, 8};

   cpu_timers dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                   .rd_en(rd_en), .pci_inta_n(pci_inta_n), .rd_data(rd_data), .nmi_irq(nmi_irq),
                   .cpu_irq(cpu_irq));
   pci_irq_agent agent (.clk_sys(clk_sys), .assert_req(pci_req), .pci_inta_n(pci_inta_n));

   // 40 mhz system clock
   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // bus cycles, comparisons and the end of the run
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input word_t v);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= v;
      wr_en   <= 1'b1;
      @(posedge clk_sys);
      wr_en   <= 1'b0;
   endtask

   // read data stand from the cycle after the strobe until the next read, so sample just past that edge
   task automatic rd(input logic [7:0] a, output word_t v);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask

   task automatic chk(input string nm, input word_t e, input word_t g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // unknown values are refused explicitly, a relational test alone would let them pass
   task automatic chk_rng(input string nm, input word_t lo, input word_t hi, input word_t g);
      samples_checked++;
      if ($isunknown(g) || g < lo || g > hi) begin
         n_mismatch++;
         $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // the whole sequence needs under 2000 cycles, so 10000 means a hang
   initial begin
      #250000;
      n_mismatch++;
      $display("watchdog expired");
      stop_test();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wr_data = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      pci_req = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      // reset values, including an unmapped offset that must read zero
      foreach (offs[i]) begin
         rd(offs[i], d);
         chk("reset value", `CSR_RESET, d);
      end
      $display("test reset done");
      // start register read back; a write to the live offset is ignored
      wr(`OFF_SET_NMI, 32'h1234_5678);
      rd(`OFF_SET_NMI, d);
      chk("start readback", 32'h1234_5678, d);
      wr(`OFF_LIVE_NMI, 32'h0bad_0bad);
      rd(`OFF_LIVE_NMI, d);
      chk("live after load", 32'h1234_5678, d);
      rd(`OFF_SET_NMI, d);
      chk("start untouched", 32'h1234_5678, d);
      $display("test map done");
      // count rate for each divider select, reads while running, stop freezes
      for (int i = 0; i < 4; i++) begin
         wr(`OFF_SET_T2, 32'h0);
         wr(`OFF_CSR, RUN_T2 | (word_t'(sels[i]) << `CLKSEL_LSB));
         rd(`OFF_CSR, d);
         chk("clock select", RUN_T2 | (word_t'(sels[i]) << `CLKSEL_LSB), d);
         repeat (36) @(posedge clk_sys);
         rd(`OFF_LIVE_T2, d0);
         rd(`OFF_LIVE_T2, d);
         chk_rng("count rises", (divs[i] == 1) ? d0 + 1 : d0, d0 + 2, d);
         repeat (120) @(posedge clk_sys);
         wr(`OFF_CSR, word_t'(sels[i]) << `CLKSEL_LSB);
         rd(`OFF_LIVE_T2, d0);
         repeat (20) @(posedge clk_sys);
         rd(`OFF_LIVE_T2, d);
         chk("stopped count", d0, d);
         chk_rng("count rate", 160 / divs[i] - 3, 170 / divs[i] + 3, d);
      end
      $display("test rate done");
      // terminal count without reload: halt, pending, interrupt, read clear
      wr(`OFF_CSR, 32'h0);
      wr(`OFF_SET_NMI, 32'hffff_fffd);
      wr(`OFF_CSR, RUN_NMI | IEN_NMI);
      // a csr read on the very edge of the event must not wipe the new pending bit
      @(posedge clk_sys);
      rd(`OFF_CSR, d);
      chk("read at event", RUN_NMI | IEN_NMI, d);
      repeat (12) @(posedge clk_sys);
      rd(`OFF_LIVE_NMI, d);
      chk("halt at max", 32'hffff_ffff, d);
      chk("nmi irq", 32'h1, {31'h0, nmi_irq});
      rd(`OFF_CSR, d);
      chk("nmi pending", RUN_NMI | IEN_NMI | PEND_NMI, d);
      rd(`OFF_CSR, d);
      chk("pending cleared", RUN_NMI | IEN_NMI, d);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("nmi irq cleared", 32'h0, {31'h0, nmi_irq});
      rd(`OFF_SET_NMI, d);
      chk("start kept", 32'hffff_fffd, d);
      wr(`OFF_CSR, 32'h0);
      wr(`OFF_CSR, RUN_NMI);
      repeat (12) @(posedge clk_sys);
      rd(`OFF_CSR, d);
      chk("restart on run", RUN_NMI | PEND_NMI, d);
      rd(`OFF_CSR, d);
      $display("test terminal done");
      // reload keeps the timer cycling; masked interrupt stays quiet until enabled
      wr(`OFF_CSR, 32'h0);
      wr(`OFF_SET_T1, 32'hffff_fff0);
      wr(`OFF_CSR, RUN_T1 | RLD_T1);
      repeat (60) @(posedge clk_sys);
      #1;
      chk("t1 irq masked", 32'h0, {31'h0, cpu_irq});
      rd(`OFF_LIVE_T1, d0);
      rd(`OFF_LIVE_T1, d);
      chk("reload moving", 32'h1, {31'h0, d !== d0});
      chk_rng("reload range", 32'hffff_fff0, 32'hffff_ffff, d);
      wr(`OFF_CSR, RUN_T1 | RLD_T1 | IEN_T1);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("t1 irq", 32'h1, {31'h0, cpu_irq});
      wr(`OFF_CSR, 32'h0);
      rd(`OFF_CSR, d);
      chk("t1 pending", PEND_T1, d);
      rd(`OFF_CSR, d);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("t1 irq cleared", 32'h0, {31'h0, cpu_irq});
      $display("test reload done");
      // pci inta# latched while disabled, reaches the cpu only once enabled
      pci_req <= 1'b1;
      repeat (8) @(posedge clk_sys);
      pci_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(`OFF_CSR, d);
      chk("pci latched", PCI_PEND, d);
      chk("pci irq held off", 32'h0, {31'h0, cpu_irq});
      wr(`OFF_CSR, PCI_EN);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pci irq", 32'h1, {31'h0, cpu_irq});
      wr(`OFF_CSR, PCI_EN | PCI_CLR);
      rd(`OFF_CSR, d);
      chk("pci cleared", PCI_EN, d);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pci irq cleared", 32'h0, {31'h0, cpu_irq});
      $display("test pci done");
      stop_test();
   end
endmodule
